// ---- sac_pkg.sv ----
// Constants and types for the converter configuration and result registers
// Functional notes
// - The conversion clock is the core clock divided by the 5-bit divider field in bits 7:3 plus one.
// - Bit 2 of the configuration selects right (0) or left (1) justification of the 10-bit result.
// - Justification applies only in 10-bit mode and is ignored in 8-bit mode.
// - Bit 1 of the configuration selects 10-bit (0) or 8-bit (1) resolution.
// - Bit 0 of the configuration selects gain 0.5 (0) or 1 (1), and reset gives gain 1.
// - Right-justified, the high byte holds zeros in 7:2 and the two top result bits in 1:0.
// - Left-justified, the high byte holds the eight top result bits.
// - In 8-bit mode the high byte holds the whole 8-bit result whatever the justification.
// - Right-justified, the low byte holds the eight lowest result bits.
// - Left-justified, the low byte holds the two lowest result bits in 7:6 and zeros in 5:0.
// - In 8-bit mode the low byte reads as zero.
// - Both result bytes are updated with the unsigned code when each conversion completes.
// - An 8-bit conversion takes two fewer conversion clock cycles than a 10-bit one.
// - The converter runs only while its enable bit is 1 and is shut down otherwise.
package sac_pkg;
  localparam logic [7:0] ADDR_CONFIG    = 8'hbc;
  localparam logic [7:0] ADDR_RES_LOW   = 8'hbd;
  localparam logic [7:0] ADDR_RES_HIGH  = 8'hbe;
  localparam logic [7:0] RST_CONFIG     = 8'hf9;
  localparam logic [7:0] RST_RES_LOW    = 8'h00;
  localparam logic [7:0] RST_RES_HIGH   = 8'h00;
  localparam int         DIV_MSB        = 7;
  localparam int         DIV_LSB        = 3;
  localparam int         JUSTIFY_BIT    = 2;
  localparam int         BYTE_MODE_BIT  = 1;
  localparam int         GAIN_BIT       = 0;
  localparam logic [3:0] BITS_TEN       = 4'ha;
  localparam logic [3:0] BITS_EIGHT     = 4'h8;

  typedef struct packed {
    logic [4:0] sarClockDivider;
    logic       justifySelect;
    logic       byteModeEnable;
    logic       inputGainSelect;
  } sac_config_type;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_CONV = 2'b01,
    SAC_DONE = 2'b11
  } sac_state_type;
endpackage : sac_pkg

// ---- sac_regs.sv ----
// Converter configuration, conversion sequencer and result byte formatting
`timescale 1ns/1ns
`default_nettype none
module sac_regs
  import sac_pkg::*;
(
  input  wire logic       clk,            // Core clock, 100 MHz
  input  wire logic       rst,            // Synchronous reset, active high
  input  wire logic [7:0] sfrAddr,        // Register address
  input  wire logic [7:0] sfrWdata,       // Write data
  input  wire logic       sfrWrite,       // Write strobe
  input  wire logic       sfrRead,        // Read strobe
  output var  logic [7:0] sfrRdata,       // Read data, valid cycle after read
  input  wire logic       converterOn,    // Converter enable bit from control register
  input  wire logic       convStart,      // Start of conversion pulse
  input  wire logic       compareIn,      // Comparator decision, conversion clock domain
  output var  logic       conversionClock,// Divided conversion clock
  output var  logic       sampleBit,      // Trial bit strobe towards the analog core
  output var  logic [9:0] trialCode,      // Successive approximation trial code
  output var  logic       inputGain,      // 1: gain 1, 0: gain 0.5
  output var  logic       powerDown,      // Analog core shutdown
  output var  logic       convBusy,       // Conversion in progress
  output var  logic       convDone        // One-cycle pulse at result update
);
  sac_config_type cfg;
  sac_config_type active;
  sac_state_type  state;
  logic [7:0]     resLow;
  logic [7:0]     resHigh;
  logic [4:0]     divCount;
  logic           sarTick;
  logic [3:0]     bitIndex;
  logic [9:0]     sar;
  logic [9:0]     nextSar;
  logic [7:0]     next_resLow;
  logic [7:0]     next_resHigh;

  // Configuration register, loaded at reset and by software writes
  always_ff @(posedge clk)
  begin
    if (rst)
      cfg <= sac_config_type'(RST_CONFIG);
    else if (sfrWrite && sfrAddr == ADDR_CONFIG)
      cfg <= sac_config_type'(sfrWdata);
  end

  // Conversion clock divider, held in reset while idle
  always_ff @(posedge clk)
  begin
    if (rst || state != SAC_CONV)
    begin
      divCount        <= 5'h00;
      sarTick         <= 1'b0;
      conversionClock <= 1'b0;
    end
    else if (divCount == active.sarClockDivider)
    begin
      divCount        <= 5'h00;
      sarTick         <= 1'b1;
      conversionClock <= 1'b0;
    end
    else
    begin
      divCount        <= divCount + 5'h01;
      sarTick         <= 1'b0;
      conversionClock <= (divCount >= (active.sarClockDivider >> 1));
    end
  end

  // Successive approximation trial for current bit
  always_comb
  begin
    nextSar = sar;
    if (!compareIn)
      nextSar[bitIndex] = 1'b0;
    if (bitIndex != 4'h0 && !(active.byteModeEnable && bitIndex == 4'h2))
      nextSar[bitIndex - 4'h1] = 1'b1;
  end

  // Conversion sequencer
  always_ff @(posedge clk)
  begin
    if (rst || !converterOn)
    begin
      state    <= SAC_IDLE;
      active   <= sac_config_type'(RST_CONFIG);
      sar      <= 10'h000;
      bitIndex <= 4'h0;
      convDone <= 1'b0;
    end
    else
    begin
      convDone <= 1'b0;
      case (state)
        SAC_IDLE:
          if (convStart)
          begin
            active   <= cfg;
            bitIndex <= 4'h9;
            sar      <= 10'h200;
            state    <= SAC_CONV;
          end
        SAC_CONV:
          if (sarTick)
          begin
            sar <= nextSar;
            // 8-bit run stops at bit 2, two clocks short
            if (bitIndex == 4'h0 || (active.byteModeEnable && bitIndex == 4'h2))
              state <= SAC_DONE;
            else
              bitIndex <= bitIndex - 4'h1;
          end
        SAC_DONE:
        begin
          convDone <= 1'b1;
          state    <= SAC_IDLE;
        end
        default:
          state <= SAC_IDLE;
      endcase
    end
  end

  // Result formatting
  always_comb
  begin
    if (active.byteModeEnable)
    begin
      next_resHigh = sar[9:2];
      next_resLow  = 8'h00;
    end
    else if (active.justifySelect)
    begin
      next_resHigh = sar[9:2];
      next_resLow  = {sar[1:0], 6'h00};
    end
    else
    begin
      next_resHigh = {6'h00, sar[9:8]};
      next_resLow  = sar[7:0];
    end
  end

  // Result bytes: conversion completion wins over a software write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      resLow  <= RST_RES_LOW;
      resHigh <= RST_RES_HIGH;
    end
    else if (state == SAC_DONE && converterOn)
    begin
      resLow  <= next_resLow;
      resHigh <= next_resHigh;
    end
    else if (sfrWrite)
    begin
      if (sfrAddr == ADDR_RES_LOW)
        resLow <= sfrWdata;
      if (sfrAddr == ADDR_RES_HIGH)
        resHigh <= sfrWdata;
    end
  end

  // Read port
  always_ff @(posedge clk)
  begin
    if (rst)
      sfrRdata <= 8'h00;
    else if (sfrRead)
      case (sfrAddr)
        ADDR_CONFIG:   sfrRdata <= cfg;
        ADDR_RES_LOW:  sfrRdata <= resLow;
        ADDR_RES_HIGH: sfrRdata <= resHigh;
        default:       sfrRdata <= 8'h00;
      endcase
  end

  // Analog-facing registered outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      inputGain <= 1'b1;
      powerDown <= 1'b1;
      convBusy  <= 1'b0;
      sampleBit <= 1'b0;
      trialCode <= 10'h000;
    end
    else
    begin
      inputGain <= cfg.inputGainSelect;
      powerDown <= !converterOn;
      convBusy  <= (state != SAC_IDLE) || (convStart && converterOn);
      sampleBit <= sarTick;
      trialCode <= sar;
    end
  end

  // Conversion clock ticks counted per conversion
  logic [4:0] tickCount;
  always_ff @(posedge clk)
  begin
    if (rst || state == SAC_IDLE)
      tickCount <= 5'h00;
    else if (sarTick)
      tickCount <= tickCount + 5'h01;
  end

  sequence s_finish;
    state == SAC_CONV ##1 state == SAC_DONE;
  endsequence

  a_divider_period: assert property (@(posedge clk) disable iff (rst)
    $rose(sarTick) |-> $past(divCount) == $past(active.sarClockDivider))
    else $error("divider tick at wrong count");
  a_justify_right: assert property (@(posedge clk) disable iff (rst)
    (state == SAC_DONE && converterOn && !active.byteModeEnable && !active.justifySelect)
      |=> resHigh[7:2] == 6'h00 && {resHigh[1:0], resLow} == $past(sar))
    else $error("right justified result wrong");
  a_justify_left: assert property (@(posedge clk) disable iff (rst)
    (state == SAC_DONE && converterOn && !active.byteModeEnable && active.justifySelect)
      |=> resLow[5:0] == 6'h00 && {resHigh, resLow[7:6]} == $past(sar))
    else $error("left justified result wrong");
  a_byte_mode: assert property (@(posedge clk) disable iff (rst)
    (state == SAC_DONE && converterOn && active.byteModeEnable)
      |=> resLow == 8'h00 && resHigh == $past(sar[9:2]))
    else $error("byte mode result wrong");
  a_tick_count: assert property (@(posedge clk) disable iff (rst || !converterOn)
    s_finish |-> tickCount == (active.byteModeEnable ? 5'h08 : 5'h0a))
    else $error("conversion length wrong");
  a_shutdown_idle: assert property (@(posedge clk) disable iff (rst)
    !converterOn |=> state == SAC_IDLE && powerDown)
    else $error("converter active while off");
  a_config_latch: assert property (@(posedge clk) disable iff (rst || !converterOn)
    (state == SAC_IDLE && convStart) |=> active == $past(cfg))
    else $error("settings not sampled at start");
  a_gain_follow: assert property (@(posedge clk) disable iff (rst)
    ##1 inputGain == $past(cfg.inputGainSelect))
    else $error("gain output mismatch");
  a_done_pulse: assert property (@(posedge clk) disable iff (rst || !converterOn)
    s_finish |=> convDone ##1 !convDone)
    else $error("done pulse wrong");
endmodule : sac_regs
`default_nettype wire

// ---- sar_adc_config_result_regs_test.sv ----
// Testbench for the converter configuration and result registers
`timescale 1ns/1ns
`default_nettype none
module sar_adc_config_result_regs_test;
  import sac_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWdata = 8'h00;
  logic       sfrWrite = 1'b0;
  logic       sfrRead = 1'b0;
  logic       converterOn = 1'b0;
  logic       convStart = 1'b0;
  logic       compareIn = 1'b0;
  logic [7:0] sfrRdata;
  logic       conversionClock;
  logic       sampleBit;
  logic [9:0] trialCode;
  logic       inputGain;
  logic       powerDown;
  logic       convBusy;
  logic       convDone;
  logic [9:0] target = 10'h000;
  logic [7:0] rv;
  logic [7:0] eh;
  logic [7:0] el;
  int         num_errors = 0;
  int         checks = 0;
  int         n10;
  int         n8;
  int         cyc;

  sac_regs uut (.clk(clk), .rst(rst), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrWrite(sfrWrite),
    .sfrRead(sfrRead), .sfrRdata(sfrRdata), .converterOn(converterOn), .convStart(convStart),
    .compareIn(compareIn), .conversionClock(conversionClock), .sampleBit(sampleBit),
    .trialCode(trialCode), .inputGain(inputGain), .powerDown(powerDown), .convBusy(convBusy),
    .convDone(convDone));

  always #5 clk = ~clk;
  // Comparator stand-in: input at or above the trial code
  always @(negedge clk) compareIn <= (trialCode <= target);

  task automatic stop_test();
    $display("Errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfrAddr = a;
    sfrWdata = d;
    sfrWrite = 1'b1;
    @(negedge clk);
    sfrWrite = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfrAddr = a;
    sfrRead = 1'b1;
    @(negedge clk);
    sfrRead = 1'b0;
    d = sfrRdata;
  endtask : rd

  // Runs one conversion; mid is written to the config while busy if it differs from cfg
  task automatic conv(input logic [7:0] cfg, input logic [7:0] mid);
    int last;
    int gap;
    int clkHigh;
    last = -1;
    gap = 0;
    clkHigh = 0;
    cyc = 0;
    wr(ADDR_CONFIG, cfg);
    @(negedge clk);
    convStart = 1'b1;
    @(negedge clk);
    convStart = 1'b0;
    chk(16'(convBusy), 16'h0001);
    while (convDone !== 1'b1)
    begin
      @(negedge clk);
      cyc++;
      if (conversionClock === 1'b1)
        clkHigh++;
      if (cyc == 1)
        chk(16'(trialCode), 16'h0200);
      if (sampleBit === 1'b1)
      begin
        if (last >= 0)
          gap = cyc - last;
        last = cyc;
      end
      if (cyc == 3 && mid != cfg)
        wr(ADDR_CONFIG, mid);
      if (cyc > 2000)
      begin
        num_errors++;
        stop_test();
      end
    end
    chk(16'(gap), 16'(cfg[7:3]) + 16'h1);
    chk(16'(clkHigh > 0), 16'h0001);
    chk(16'(conversionClock), 16'h0000);
  endtask : conv

  task automatic t_reset();
    rd(ADDR_CONFIG, rv);
    chk(16'(rv), 16'(RST_CONFIG));
    rd(ADDR_RES_LOW, rv);
    chk(16'(rv), 16'h0000);
    rd(ADDR_RES_HIGH, rv);
    chk(16'(rv), 16'h0000);
    rd(8'hbf, rv);
    chk(16'(rv), 16'h0000);
    chk(16'(inputGain), 16'h0001);
    chk(16'(powerDown), 16'h0001);
  endtask : t_reset

  task automatic t_cfg();
    wr(ADDR_CONFIG, 8'h0a);
    rd(ADDR_CONFIG, rv);
    chk(16'(rv), 16'h000a);
    chk(16'(inputGain), 16'h0000);
    wr(ADDR_RES_LOW, 8'h5a);
    rd(ADDR_RES_LOW, rv);
    chk(16'(rv), 16'h005a);
    converterOn = 1'b1;
    repeat (3) @(negedge clk);
    chk(16'(powerDown), 16'h0000);
  endtask : t_cfg

  task automatic t_formats();
    for (int i = 0; i < 4; i++)
    begin
      target = i[0] ? 10'h2c9 : 10'h136;
      eh = (i[1] | i[0]) ? target[9:2] : {6'h00, target[9:8]};
      el = i[1] ? 8'h00 : (i[0] ? {target[1:0], 6'h00} : target[7:0]);
      conv({5'h01, i[0], i[1], 1'b1}, {5'h01, i[0], i[1], 1'b1});
      if (i == 0)
        n10 = cyc;
      if (i == 2)
        n8 = cyc;
      rd(ADDR_RES_HIGH, rv);
      chk(16'(rv), 16'(eh));
      rd(ADDR_RES_LOW, rv);
      chk(16'(rv), 16'(el));
      chk(16'(convBusy), 16'h0000);
    end
    chk(16'(n10 - n8), 16'h0004);
  endtask : t_formats

  task automatic t_midchange();
    target = 10'h2c9;
    conv(8'h08, 8'h0c);
    rd(ADDR_RES_HIGH, rv);
    chk(16'(rv), 16'h0002);
  endtask : t_midchange

  task automatic t_abort();
    int dones;
    dones = 0;
    @(negedge clk);
    convStart = 1'b1;
    @(negedge clk);
    convStart = 1'b0;
    repeat (5) @(negedge clk);
    converterOn = 1'b0;
    repeat (100)
    begin
      @(negedge clk);
      if (convDone === 1'b1)
        dones++;
    end
    chk(16'(dones), 16'h0000);
    chk(16'(powerDown), 16'h0001);
  endtask : t_abort

  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_cfg();
    t_formats();
    t_midchange();
    t_abort();
    stop_test();
  end
endmodule : sar_adc_config_result_regs_test
`default_nettype wire
